// [hw/ispc_top.sv]
// module: interrupt sensing, pending hold, masking and fixed priority encoder
//
// Overview of operation
// - internal sources take vectors 12..44, priority falls as vector rises
// - system control bit 2 selects nonmaskable edge: 0 falling, 1 rising
// - nonmaskable edge requests regardless of mask, vector 3, sets mask
// - sense bit 0 requests on low level, 1 on falling edge
// - per-line enable bit, reset 0, gates new requests
// - lines 0..7 take vectors 4..11, line 0 highest
// - mask flag blocks all eight lines together
// - accepting a maskable request sets the mask flag
// - edge captured while enabled stays pending until served
// - clearing enable keeps pending edge but ignores new edges
// - pending edge with enable cleared still dispatched when mask is 0
// - pending cleared when mask 1, sense 0 and enable 0
// - internal requests blocked by mask, each gated by its enable
// - nonmaskable input and lines 0,1,2,6 can wake from standby
// - line detection samples pin level whatever the pin direction
// - vector table bytes 0002..0005 reserved, reset vector at 0000
// - with mask 1 only nonmaskable accepted, others stay pending
// - only highest priority accepted request passed with its vector
// - nonmaskable always accepted except in reset or hardware standby
`timescale 1ns/1ns
module ispc_top
  import ispc_pkg::*;
#(
  parameter int NLINES = ISPC_NUM_LINES,
  parameter int NINT   = ISPC_NUM_INTERNAL
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // register port
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // pins
  input  wire logic              nonmask_pin,
  input  wire logic [NLINES-1:0] external_request_lines,
  input  wire logic              hw_standby,
  // internal sources, level requests with their enables
  input  wire logic [NINT-1:0]   int_req,
  input  wire logic [NINT-1:0]   int_en,
  // processor side
  input  wire logic              cpu_mask_flag,
  input  wire logic              cpu_accept,
  output logic                   irq_valid,
  output logic      [5:0]        irq_vector,
  output logic      [6:0]        irq_vec_addr,
  output logic                   irq_set_mask,
  output logic                   wake_req
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]        system_control_ff, nxt_system_control;
  logic [7:0]        line_sense_select_ff, nxt_line_sense_select;
  logic [7:0]        line_request_enable_ff, nxt_line_request_enable;
  logic [7:0]        rdata_ff, nxt_rdata;
  logic [1:0]        nmi_sync_ff, nxt_nmi_sync;
  logic              nmi_last_ff, nxt_nmi_last;
  logic              nmi_pend_ff, nxt_nmi_pend;
  logic [NLINES-1:0] ln_s1_ff, ln_s2_ff, ln_last_ff;
  logic [NLINES-1:0] nxt_ln_s1, nxt_ln_s2, nxt_ln_last;
  logic [NLINES-1:0] ln_pend_ff, nxt_ln_pend;
  logic              valid_ff, nxt_valid;
  logic [5:0]        vec_ff, nxt_vec;
  logic [6:0]        vaddr_ff, nxt_vaddr;
  logic              setm_ff, nxt_setm;
  logic              wake_ff, nxt_wake;

  logic              nmi_edge;
  logic [NLINES-1:0] ln_fall, ln_req;
  logic [NINT-1:0]   int_act;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_comb
  begin
    nxt_system_control      = system_control_ff;
    nxt_line_sense_select   = line_sense_select_ff;
    nxt_line_request_enable = line_request_enable_ff;
    nxt_rdata               = 8'h00;
    if (reg_wr)
    begin
      case (reg_addr)
        ISPC_ADDR_SYSCTL: nxt_system_control = (reg_wdata & ~ISPC_SYSCTL_RO)
                                               | ISPC_SYSCTL_RO;
        ISPC_ADDR_SENSE:  nxt_line_sense_select   = reg_wdata;
        ISPC_ADDR_ENABLE: nxt_line_request_enable = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ISPC_ADDR_SYSCTL: nxt_rdata = system_control_ff;
        ISPC_ADDR_SENSE:  nxt_rdata = line_sense_select_ff;
        ISPC_ADDR_ENABLE: nxt_rdata = line_request_enable_ff;
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  always_comb
  begin
    nxt_nmi_sync = {nmi_sync_ff[0], nonmask_pin};
    nxt_nmi_last = nmi_sync_ff[1];
    nxt_ln_s1    = external_request_lines;
    nxt_ln_s2    = ln_s1_ff;
    nxt_ln_last  = ln_s2_ff;
    nmi_edge = system_control_ff[ISPC_NMIEDGE_BIT] ? (nmi_sync_ff[1] & ~nmi_last_ff)
                                                   : (~nmi_sync_ff[1] & nmi_last_ff);
  end

  // ----------------------------------------
  // per line request and pending hold
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++)
    begin : g_line
      always_comb
      begin
        ln_fall[gi] = ln_last_ff[gi] & ~ln_s2_ff[gi];
        nxt_ln_pend[gi] = ln_pend_ff[gi];
        if (cpu_accept && valid_ff && vec_ff == ISPC_VEC_LINE0 + 6'(gi))
          nxt_ln_pend[gi] = 1'b0;
        if (cpu_mask_flag && !line_sense_select_ff[gi] && !line_request_enable_ff[gi])
          nxt_ln_pend[gi] = 1'b0;
        if (line_sense_select_ff[gi] && line_request_enable_ff[gi] && ln_fall[gi])
          nxt_ln_pend[gi] = 1'b1;
        // level mode needs enable; edge mode uses held pending
        ln_req[gi] = line_sense_select_ff[gi] ? ln_pend_ff[gi]
                   : (line_request_enable_ff[gi] & ~ln_s2_ff[gi]);
      end

      edge_capture_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && ln_fall[gi] && line_sense_select_ff[gi] && line_request_enable_ff[gi])
          |=> ln_pend_ff[gi])
        else $error("enabled edge not held pending");
      pend_keep_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && ln_pend_ff[gi] && !cpu_accept && line_sense_select_ff[gi])
          |=> ln_pend_ff[gi])
        else $error("pending edge lost");
      edge_ignored_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && line_sense_select_ff[gi] && !line_request_enable_ff[gi] && !ln_pend_ff[gi])
          |=> !ln_pend_ff[gi])
        else $error("edge taken while disabled");
      pend_clear_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && cpu_mask_flag && !line_sense_select_ff[gi] && !line_request_enable_ff[gi])
          |=> !ln_pend_ff[gi])
        else $error("pending not cleared");
    end
  endgenerate

  // ----------------------------------------
  // nonmaskable pending and priority encoder
  // ----------------------------------------
  always_comb
  begin
    nxt_nmi_pend = nmi_pend_ff;
    if (cpu_accept && valid_ff && vec_ff == ISPC_VEC_NMI)
      nxt_nmi_pend = 1'b0;
    if (hw_standby)
      nxt_nmi_pend = 1'b0;
    else if (nmi_edge)
      nxt_nmi_pend = 1'b1;
    int_act   = int_req & int_en;
    nxt_valid = 1'b0;
    nxt_vec   = ISPC_VEC_NONE;
    nxt_setm  = 1'b0;
    if (nmi_pend_ff && !hw_standby)
    begin
      nxt_valid = 1'b1;
      nxt_vec   = ISPC_VEC_NMI;
    end
    else if (!cpu_mask_flag)
    begin
      for (int i = NINT - 1; i >= 0; i--)
      begin
        if (int_act[i])
        begin
          nxt_valid = 1'b1;
          nxt_vec   = ISPC_VEC_INT0 + 6'(i);
        end
      end
      for (int i = NLINES - 1; i >= 0; i--)
      begin
        if (ln_req[i])
        begin
          nxt_valid = 1'b1;
          nxt_vec   = ISPC_VEC_LINE0 + 6'(i);
        end
      end
    end
    nxt_setm  = nxt_valid;
    nxt_vaddr = {nxt_vec, 1'b0};
    nxt_wake  = nmi_edge | (|(ISPC_WAKE_LINES & ~ln_s2_ff & line_request_enable_ff));
  end

  // ----------------------------------------
  // registering
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      system_control_ff      <= ISPC_SYSCTL_RESET;
      line_sense_select_ff   <= ISPC_SENSE_RESET;
      line_request_enable_ff <= ISPC_ENABLE_RESET;
      rdata_ff    <= 8'h00;
      nmi_sync_ff <= 2'h3;
      nmi_last_ff <= 1'b1;
      nmi_pend_ff <= 1'b0;
      ln_s1_ff    <= '1;
      ln_s2_ff    <= '1;
      ln_last_ff  <= '1;
      ln_pend_ff  <= '0;
      valid_ff    <= 1'b0;
      vec_ff      <= ISPC_VEC_NONE;
      vaddr_ff    <= 7'h00;
      setm_ff     <= 1'b0;
      wake_ff     <= 1'b0;
    end
    else if (clk_en)
    begin
      system_control_ff      <= nxt_system_control;
      line_sense_select_ff   <= nxt_line_sense_select;
      line_request_enable_ff <= nxt_line_request_enable;
      rdata_ff    <= nxt_rdata;
      nmi_sync_ff <= nxt_nmi_sync;
      nmi_last_ff <= nxt_nmi_last;
      nmi_pend_ff <= nxt_nmi_pend;
      ln_s1_ff    <= nxt_ln_s1;
      ln_s2_ff    <= nxt_ln_s2;
      ln_last_ff  <= nxt_ln_last;
      ln_pend_ff  <= nxt_ln_pend;
      valid_ff    <= nxt_valid;
      vec_ff      <= nxt_vec;
      vaddr_ff    <= nxt_vaddr;
      setm_ff     <= nxt_setm;
      wake_ff     <= nxt_wake;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign irq_valid    = valid_ff;
  assign irq_vector   = vec_ff;
  assign irq_vec_addr = vaddr_ff;
  assign irq_set_mask = setm_ff;
  assign wake_req     = wake_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  masked_no_maskable_a: assert property (@(posedge clk) disable iff (rst)
    (clk_en && cpu_mask_flag && !nmi_pend_ff) |=> !valid_ff)
    else $error("maskable request passed while masked");
  vector_range_a: assert property (@(posedge clk) disable iff (rst)
    valid_ff |-> (vec_ff >= ISPC_VEC_NMI && vec_ff <= 6'h2c))
    else $error("vector outside table");
  vec_addr_a: assert property (@(posedge clk) disable iff (rst)
    irq_vec_addr == {irq_vector, 1'b0})
    else $error("vector address not twice vector");
  nmi_first_a: assert property (@(posedge clk) disable iff (rst)
    (clk_en && nmi_pend_ff && !hw_standby) |=> (valid_ff && vec_ff == ISPC_VEC_NMI))
    else $error("nonmaskable not selected");
  setmask_a: assert property (@(posedge clk) disable iff (rst)
    irq_set_mask == irq_valid)
    else $error("mask set not paired with request");
  sequence nmi_fall_s;
    (clk_en && nmi_sync_ff[1] && !system_control_ff[ISPC_NMIEDGE_BIT]) ##1
    (clk_en && !nmi_sync_ff[1] && !system_control_ff[ISPC_NMIEDGE_BIT] && !hw_standby);
  endsequence
  sequence nmi_rise_s;
    (clk_en && !nmi_sync_ff[1] && system_control_ff[ISPC_NMIEDGE_BIT]) ##1
    (clk_en && nmi_sync_ff[1] && system_control_ff[ISPC_NMIEDGE_BIT] && !hw_standby);
  endsequence
  nmi_fall_a: assert property (@(posedge clk) disable iff (rst)
    nmi_fall_s |=> nmi_pend_ff)
    else $error("falling nonmaskable edge missed");
  nmi_rise_a: assert property (@(posedge clk) disable iff (rst)
    nmi_rise_s |=> nmi_pend_ff)
    else $error("rising nonmaskable edge missed");
  standby_nmi_a: assert property (@(posedge clk) disable iff (rst)
    (clk_en && hw_standby) |=> (!nmi_pend_ff && vec_ff != ISPC_VEC_NMI))
    else $error("nonmaskable kept in standby");
  int_first_a: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !cpu_mask_flag && !nmi_pend_ff && !(|ln_req) && int_act[0])
      |=> (vec_ff == ISPC_VEC_INT0))
    else $error("internal source 0 not highest internal");
  line0_prio_a: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !cpu_mask_flag && !nmi_pend_ff && ln_req[0]) |=> (vec_ff == ISPC_VEC_LINE0))
    else $error("line 0 not highest");
endmodule : ispc_top

// [inc/ispc_pkg.sv]
// package: register map, field positions and vector numbers of the interrupt controller
package ispc_pkg;
  localparam logic [15:0] ISPC_ADDR_SYSCTL   = 16'hffc4;
  localparam logic [15:0] ISPC_ADDR_SENSE    = 16'hffc6;
  localparam logic [15:0] ISPC_ADDR_ENABLE   = 16'hffc7;
  localparam int          ISPC_NMIEDGE_BIT   = 2;
  localparam logic [7:0]  ISPC_SYSCTL_RESET  = 8'h09;
  localparam logic [7:0]  ISPC_SYSCTL_RO     = 8'h08;
  localparam logic [7:0]  ISPC_SENSE_RESET   = 8'h00;
  localparam logic [7:0]  ISPC_ENABLE_RESET  = 8'h00;
  localparam int          ISPC_NUM_LINES     = 8;
  localparam int          ISPC_NUM_INTERNAL  = 33;
  localparam logic [5:0]  ISPC_VEC_NMI       = 6'h03;
  localparam logic [5:0]  ISPC_VEC_LINE0     = 6'h04;
  localparam logic [5:0]  ISPC_VEC_INT0      = 6'h0c;
  localparam logic [5:0]  ISPC_VEC_NONE      = 6'h00;
  localparam logic [7:0]  ISPC_WAKE_LINES    = 8'h47;
endpackage : ispc_pkg

// [tb/ispc_cpu_model.sv]
// processor core model: takes requests after a set latency and keeps the mask flag
`timescale 1ns/1ns
module ispc_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // controller side
  input  wire logic       irq_valid,
  input  wire logic [5:0] irq_vector,
  input  wire logic [6:0] irq_vec_addr,
  input  wire logic       irq_set_mask,
  output logic            cpu_mask_flag,
  output logic            cpu_accept,
  // bench side
  input  wire logic       mask_wr,
  input  wire logic       mask_val,
  input  wire logic [3:0] lat,
  output logic      [5:0] last_vec,
  output logic      [6:0] last_addr,
  output logic      [7:0] n_acc
);
  logic [3:0] wait_ff, nxt_wait;
  logic [2:0] busy_ff, nxt_busy;
  logic       nxt_accept;
  // wait lat cycles, then accept; hold off while the pending state settles
  always_comb
  begin
    nxt_wait   = (!irq_valid || cpu_accept) ? 4'h0 : (wait_ff == lat ? wait_ff : wait_ff + 4'h1);
    nxt_accept = irq_valid && wait_ff == lat && busy_ff == 3'h0 && !cpu_accept;
    nxt_busy   = cpu_accept ? 3'h4 : busy_ff - {2'h0, busy_ff != 3'h0};
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_ff       <= 4'h0;
      busy_ff       <= 3'h0;
      cpu_accept    <= 1'b0;
      cpu_mask_flag <= 1'b1;
      last_vec      <= 6'h00;
      last_addr     <= 7'h00;
      n_acc         <= 8'h00;
    end
    else
    begin
      wait_ff    <= nxt_wait;
      busy_ff    <= nxt_busy;
      cpu_accept <= nxt_accept;
      if (cpu_accept)
      begin
        last_vec  <= irq_vector;
        last_addr <= irq_vec_addr;
        n_acc     <= n_acc + 8'h01;
      end
      if (cpu_accept && irq_set_mask)
        cpu_mask_flag <= 1'b1;
      else if (mask_wr)
        cpu_mask_flag <= mask_val;
    end
  end
endmodule : ispc_cpu_model

// [tb/ispc_top_tb_top.sv]
// testbench: register port, sensing, masking, priority and vectors of the controller
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module ispc_top_tb_top;
  import ispc_pkg::*;
  logic clk, rst, clk_en, reg_wr, reg_rd, nonmask_pin, hw_standby, mask_wr, mask_val;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ext_lines, n_acc;
  logic [32:0] int_req, int_en;
  logic cpu_mask_flag, cpu_accept, irq_valid, irq_set_mask, wake_req;
  logic [5:0] irq_vector, last_vec;
  logic [6:0] irq_vec_addr, last_addr;
  logic [3:0] lat;
  int errors, n_tests, cyc;
  ispc_top dut (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nonmask_pin(nonmask_pin), .external_request_lines(ext_lines), .hw_standby(hw_standby),
    .int_req(int_req), .int_en(int_en), .cpu_mask_flag(cpu_mask_flag),
    .cpu_accept(cpu_accept), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_vec_addr(irq_vec_addr), .irq_set_mask(irq_set_mask), .wake_req(wake_req));
  ispc_cpu_model cpu (.clk(clk), .rst(rst), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_vec_addr(irq_vec_addr), .irq_set_mask(irq_set_mask), .cpu_mask_flag(cpu_mask_flag),
    .cpu_accept(cpu_accept), .mask_wr(mask_wr), .mask_val(mask_val), .lat(lat),
    .last_vec(last_vec), .last_addr(last_addr), .n_acc(n_acc));
  // ----------------
  // bus and checks
  // ----------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    @(posedge clk) `CHK(reg_rdata, e)
  endtask : rd
  task automatic mask(input logic v);
    @(posedge clk) begin mask_wr <= 1'b1; mask_val <= v; end
    @(posedge clk) mask_wr <= 1'b0;
  endtask : mask
  task automatic acc(input logic [5:0] v);
    logic [7:0] n0;
    n0 = n_acc;
    for (int i = 0; i < 60 && n_acc === n0; i++) @(posedge clk);
    `CHK(n_acc, n0 + 8'h01)
    `CHK(last_vec, v)
    `CHK(last_addr, {v, 1'b0})
  endtask : acc
  task automatic none(input int n);
    logic [7:0] n0;
    n0 = n_acc;
    repeat (n) @(posedge clk);
    `CHK(n_acc, n0)
  endtask : none
  task automatic pulse(input int k);
    ext_lines[k] <= 1'b0;
    repeat (3) @(posedge clk);
    ext_lines[k] <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic wrap_up;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end
  // ----------------
  // scenarios
  // ----------------
  initial
  begin
    {rst, clk_en, reg_wr, reg_rd, nonmask_pin, hw_standby, mask_wr, mask_val} = 8'hc8;
    reg_addr  = 16'h0000;
    reg_wdata = 8'h00;
    int_req   = '0;
    int_en    = '0;
    lat       = 4'h0;
    ext_lines = 8'hff;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ISPC_ADDR_SYSCTL, 8'h09);
    rd(ISPC_ADDR_SENSE, 8'h00);
    rd(ISPC_ADDR_ENABLE, 8'h00);
    wr(ISPC_ADDR_SYSCTL, 8'h00);
    rd(ISPC_ADDR_SYSCTL, 8'h08);
    wr(16'hffc5, 8'hff);
    rd(16'hffc5, 8'h00);
    ext_lines[0] <= 1'b0;
    mask(1'b0);
    none(15);
    ext_lines <= 8'hff;
    wr(ISPC_ADDR_ENABLE, 8'hff);
    for (int k = 0; k < 8; k++)
    begin
      lat <= 4'(k);
      ext_lines[k] <= 1'b0;
      mask(1'b0);
      acc(6'(4 + k));
      `CHK(cpu_mask_flag, 1'b1)
      ext_lines <= 8'hff;
      repeat (6) @(posedge clk);
    end
    ext_lines <= 8'hd7;
    mask(1'b0);
    acc(6'h07);
    none(12);
    ext_lines[3] <= 1'b1;
    repeat (6) @(posedge clk);
    mask(1'b0);
    acc(6'h09);
    ext_lines <= 8'hff;
    wr(ISPC_ADDR_SENSE, 8'h04);
    wr(ISPC_ADDR_ENABLE, 8'h04);
    pulse(2);
    wr(ISPC_ADDR_ENABLE, 8'h00);
    none(10);
    mask(1'b0);
    acc(6'h06);
    mask(1'b0);
    pulse(2);
    none(15);
    wr(ISPC_ADDR_ENABLE, 8'h04);
    mask(1'b1);
    pulse(2);
    wr(ISPC_ADDR_ENABLE, 8'h00);
    wr(ISPC_ADDR_SENSE, 8'h00);
    wr(ISPC_ADDR_SENSE, 8'h04);
    mask(1'b0);
    none(15);
    mask(1'b1);
    nonmask_pin <= 1'b0;
    acc(6'h03);
    nonmask_pin <= 1'b1;
    none(10);
    wr(ISPC_ADDR_SYSCTL, 8'h04);
    nonmask_pin <= 1'b0;
    none(10);
    nonmask_pin <= 1'b1;
    acc(6'h03);
    hw_standby <= 1'b1;
    pulse(0);
    nonmask_pin <= 1'b0;
    repeat (4) @(posedge clk);
    nonmask_pin <= 1'b1;
    none(12);
    hw_standby <= 1'b0;
    int_en <= '1;
    int_req <= {1'b1, 31'h0, 1'b1};
    none(10);
    mask(1'b0);
    acc(6'h0c);
    int_req[0] <= 1'b0;
    mask(1'b0);
    acc(6'h2c);
    int_en[32] <= 1'b0;
    mask(1'b0);
    none(10);
    int_req <= '0;
    mask(1'b1);
    wr(ISPC_ADDR_SENSE, 8'h00);
    wr(ISPC_ADDR_ENABLE, 8'hff);
    for (int k = 0; k < 8; k++)
    begin
      ext_lines[k] <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(wake_req, k == 0 || k == 1 || k == 2 || k == 6)
      ext_lines <= 8'hff;
      repeat (8) @(posedge clk);
    end
    clk_en <= 1'b0;
    wr(ISPC_ADDR_ENABLE, 8'h00);
    clk_en <= 1'b1;
    rd(ISPC_ADDR_ENABLE, 8'hff);
    wrap_up();
  end
endmodule : ispc_top_tb_top
